// file: hw/sfp_pkg.sv
package sfp_pkg;
    // Register addresses on the serial port
    localparam logic [12:0] ADDR_BURST_PULSE_COUNT = 13'h013e;
    localparam logic [12:0] ADDR_LOOP_FEEDBACK_SELECT = 13'h013f;
    localparam logic [12:0] ADDR_BLOCK_POWER_DOWN = 13'h0140;
    localparam logic [12:0] ADDR_DYNAMIC_DELAY_ENABLE = 13'h0141;
    localparam logic [12:0] ADDR_DELAY_STEP_COUNT = 13'h0142;

    // Reset values
    localparam logic [7:0] RST_BURST_PULSE_COUNT = 8'h03;
    localparam logic [7:0] RST_LOOP_FEEDBACK_SELECT = 8'h00;
    localparam logic [7:0] RST_BLOCK_POWER_DOWN = 8'he0;
    localparam logic [7:0] RST_DYNAMIC_DELAY_ENABLE = 8'h00;
    localparam logic [7:0] RST_DELAY_STEP_COUNT = 8'h00;

    // Writable bits; the rest read as zero
    localparam logic [7:0] MASK_BURST_PULSE_COUNT = 8'h03;
    localparam logic [7:0] MASK_LOOP_FEEDBACK_SELECT = 8'hbf;
    localparam logic [7:0] MASK_FULL = 8'hff;

    // Field positions
    localparam int BURST_COUNT_LSB = 0;
    localparam int BURST_COUNT_MSB = 1;

    // Frame-reference source and sync-mode codes
    localparam logic [1:0] SRC_NORMAL_SYNC = 2'h0;
    localparam logic [1:0] SRC_RECLOCKED = 2'h1;
    localparam logic [1:0] SRC_PULSER = 2'h2;
    localparam logic [1:0] SRC_CONTINUOUS = 2'h3;
    localparam logic [1:0] SYNC_MODE_SPI_PULSER = 2'h3;

    // Serial frame layout
    localparam logic [4:0] SPI_ADDR_LAST_BIT = 5'h0f;
    localparam logic [4:0] SPI_DATA_LAST_BIT = 5'h17;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h18;
    localparam int SPI_READ_BIT = 14;

    // Idle cycles between generated pulses
    localparam int PULSE_GAP_CYC = 3;

    typedef struct packed {
        logic second_loop_reference_select;
        logic reserved6;
        logic second_loop_ndiv_input_select;
        logic [1:0] first_loop_ndiv_input_select;
        logic [1:0] feedback_source_select;
        logic feedback_select_power_on;
    } sfp_loop_t;

    typedef struct packed {
        logic first_loop_powerdown;
        logic oscillator_regulator_powerdown;
        logic oscillator_core_powerdown;
        logic ref_osc_input_powerdown;
        logic frame_ref_global_powerdown;
        logic frame_ref_block_powerdown;
        logic frame_ref_delay_powerdown;
        logic pulse_generator_powerdown;
    } sfp_power_t;

    typedef struct packed {
        logic wr;
        logic [12:0] addr;
        logic [7:0] data;
    } sfp_write_t;
endpackage

// file: hw/sfp_spi_port.sv
`timescale 1ns/1ns
module sfp_spi_port (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    input wire logic [7:0] rd_data,
    output sfp_pkg::sfp_write_t wr_r,
    output logic spi_sdo,
    output logic spi_sdo_oe_n
);
    logic sck_s1_r, sck_s2_r, sck_s3_r;
    logic cs_n_s1_r, cs_n_s2_r;
    logic sdi_s1_r, sdi_s2_r;
    logic [4:0] cnt_r, cnt_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic read_r, read_nxt;
    logic load_r, load_nxt;
    logic [7:0] rdout_r, rdout_nxt;
    logic sdo_r, sdo_nxt;
    logic oe_n_r, oe_n_nxt;
    sfp_pkg::sfp_write_t wr_nxt;
    logic rise, fall;

    assign rise = sck_s2_r & ~sck_s3_r;
    assign fall = ~sck_s2_r & sck_s3_r;
    assign spi_sdo = sdo_r;
    assign spi_sdo_oe_n = oe_n_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            cs_n_s1_r <= 1'b1;
            cs_n_s2_r <= 1'b1;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= spi_sck;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            cs_n_s1_r <= spi_cs_n;
            cs_n_s2_r <= cs_n_s1_r;
            sdi_s1_r <= spi_sdi;
            sdi_s2_r <= sdi_s1_r;
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        read_nxt = read_r;
        load_nxt = 1'b0;
        rdout_nxt = rdout_r;
        sdo_nxt = sdo_r;
        oe_n_nxt = oe_n_r;
        wr_nxt = '{wr: 1'b0, addr: wr_r.addr, data: wr_r.data};
        if (cs_n_s2_r) begin
            cnt_nxt = 5'h00;
            oe_n_nxt = 1'b1;
        end else begin
            if (load_r) begin
                rdout_nxt = rd_data;
            end
            if (rise && cnt_r < sfp_pkg::SPI_FRAME_BITS) begin
                shift_nxt = {shift_r[14:0], sdi_s2_r};
                cnt_nxt = cnt_r + 5'h01;
                if (cnt_r == sfp_pkg::SPI_ADDR_LAST_BIT) begin
                    wr_nxt.addr = {shift_r[11:0], sdi_s2_r};
                    read_nxt = shift_r[sfp_pkg::SPI_READ_BIT];
                    load_nxt = 1'b1;
                end
                if (cnt_r == sfp_pkg::SPI_DATA_LAST_BIT && !read_r) begin
                    wr_nxt.wr = 1'b1;
                    wr_nxt.data = {shift_r[6:0], sdi_s2_r};
                end
            end
            if (fall && read_r && cnt_r > sfp_pkg::SPI_ADDR_LAST_BIT && cnt_r < sfp_pkg::SPI_FRAME_BITS) begin
                sdo_nxt = rdout_r[7];
                rdout_nxt = {rdout_r[6:0], 1'b0};
                oe_n_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_r <= 5'h00;
            shift_r <= 16'h0000;
            read_r <= 1'b0;
            load_r <= 1'b0;
            rdout_r <= 8'h00;
            sdo_r <= 1'b0;
            oe_n_r <= 1'b1;
            wr_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            read_r <= read_nxt;
            load_r <= load_nxt;
            rdout_r <= rdout_nxt;
            sdo_r <= sdo_nxt;
            oe_n_r <= oe_n_nxt;
            wr_r <= wr_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_write_single_pulse: assert property (wr_r.wr |=> !wr_r.wr)
        else $error("write strobe longer than one cycle");
    a_sdo_idle_released: assert property (cs_n_s2_r |=> spi_sdo_oe_n)
        else $error("data out driven outside a frame");
endmodule

// file: hw/sfp_pulse_seq.sv
`timescale 1ns/1ns
module sfp_pulse_seq #(
    parameter int CNT_W = 8,
    parameter int GAP_CYC = 3
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [CNT_W-1:0] count,
    output logic pulse_r,
    output logic busy_r
);
    if (CNT_W < 1 || GAP_CYC < 1 || GAP_CYC > 256) begin : g_bad_param
        $error("sfp_pulse_seq: CNT_W must be at least 1 and GAP_CYC 1 to 256");
    end

    typedef enum logic [1:0] {
        SFP_IDLE = 2'b00,
        SFP_HIGH = 2'b01,
        SFP_GAP = 2'b10
    } sfp_seq_t;

    sfp_seq_t state_r, state_nxt;
    logic [CNT_W-1:0] rem_r, rem_nxt;
    logic [7:0] gap_r, gap_nxt;

    always_comb begin
        state_nxt = state_r;
        rem_nxt = rem_r;
        gap_nxt = gap_r;
        case (state_r)
            SFP_IDLE: begin
                if (start && count != '0) begin
                    state_nxt = SFP_HIGH;
                    rem_nxt = count;
                end
            end
            SFP_HIGH: begin
                rem_nxt = rem_r - 1'b1;
                gap_nxt = 8'(GAP_CYC - 1);
                state_nxt = (rem_r == 1) ? SFP_IDLE : SFP_GAP;
            end
            SFP_GAP: begin
                gap_nxt = gap_r - 8'h01;
                if (gap_r == 8'h00) begin
                    state_nxt = SFP_HIGH;
                end
            end
            default: state_nxt = SFP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= SFP_IDLE;
            rem_r <= '0;
            gap_r <= 8'h00;
            pulse_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rem_r <= rem_nxt;
            gap_r <= gap_nxt;
            pulse_r <= (state_nxt == SFP_HIGH);
            busy_r <= (state_nxt != SFP_IDLE);
        end
    end
endmodule

// file: hw/sfp_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Burst write fires pulses when pulser selected, powered, in sync mode 3 and not busy
// - Count field encodes 1,2,4,8; resets 3
// - Bit7 picks second loop reference
// - Bit5 picks second loop divider input
// - Bits4:3 pick first loop divider input
// - Bits2:1 pick zero-delay feedback clock
// - Bit0 powers feedback select; software sets
// - Bits7:5 power down loop, regulator, core
// - Bit4 powers down reference oscillator input
// - Bit3 gates per-output frame-reference powerdown
// - Bit2 kills frame-reference and SYNC
// - Bit1 powers down frame-reference delay
// - Bit0 powers down pulse generator
// - Enable bits choose dynamic delay outputs
// - Step count write starts delay adjustment when outputs enabled and not busy
// - Step count zero means no adjustment
// - Source field: sync, reclock, pulser, continuous
// - Sync mode 3 fires pulser on write
module sfp_regs #(
    parameter int NUM_FR_OUT = 7,
    parameter int GAP_CYC = sfp_pkg::PULSE_GAP_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    input wire logic [1:0] frame_ref_source_select,
    input wire logic [1:0] sync_mode,
    input wire logic [NUM_FR_OUT-1:0] per_output_disable_mode,
    output sfp_pkg::sfp_loop_t loop_ctrl_r,
    output sfp_pkg::sfp_power_t power_ctrl_r,
    output logic [NUM_FR_OUT-1:0] frame_ref_output_off_r,
    output logic frame_ref_sync_avail_r,
    output logic frame_ref_burst_pulse,
    output logic burst_busy,
    output logic [7:0] output_dyn_delay_enable_r,
    output logic [7:0] delay_step_targets_r,
    output logic delay_step_pulse,
    output logic delay_busy
);
    if (NUM_FR_OUT < 1) begin : g_bad_param
        $error("sfp_regs: NUM_FR_OUT must be at least 1");
    end

    sfp_pkg::sfp_write_t wr;
    logic [7:0] rd_data;
    logic [1:0] burst_cnt_r, burst_cnt_nxt;
    sfp_pkg::sfp_loop_t loop_nxt;
    sfp_pkg::sfp_power_t power_nxt;
    logic [7:0] dde_nxt;
    logic [7:0] step_cnt_r, step_cnt_nxt;
    logic burst_start_r, burst_start_nxt;
    logic [3:0] burst_len_r, burst_len_nxt;
    logic step_start_r, step_start_nxt;
    logic [7:0] targets_nxt;
    logic [NUM_FR_OUT-1:0] fr_off_nxt;
    logic pulser_ready;

    sfp_spi_port u_spi (
        .core_clk(core_clk),
        .srst(srst),
        .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi),
        .rd_data(rd_data),
        .wr_r(wr),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n)
    );

    // Read mux; reserved bits come back zero
    always_comb begin
        case (wr.addr)
            sfp_pkg::ADDR_BURST_PULSE_COUNT: rd_data = {6'h00, burst_cnt_r};
            sfp_pkg::ADDR_LOOP_FEEDBACK_SELECT: rd_data = loop_ctrl_r & sfp_pkg::MASK_LOOP_FEEDBACK_SELECT;
            sfp_pkg::ADDR_BLOCK_POWER_DOWN: rd_data = power_ctrl_r;
            sfp_pkg::ADDR_DYNAMIC_DELAY_ENABLE: rd_data = output_dyn_delay_enable_r;
            sfp_pkg::ADDR_DELAY_STEP_COUNT: rd_data = step_cnt_r;
            default: rd_data = 8'h00;
        endcase
    end

    // Pulser usable only when selected and powered
    assign pulser_ready = frame_ref_source_select == sfp_pkg::SRC_PULSER
        && !power_ctrl_r.frame_ref_block_powerdown
        && !power_ctrl_r.pulse_generator_powerdown
        && sync_mode == sfp_pkg::SYNC_MODE_SPI_PULSER;

    always_comb begin
        burst_cnt_nxt = burst_cnt_r;
        loop_nxt = loop_ctrl_r;
        power_nxt = power_ctrl_r;
        dde_nxt = output_dyn_delay_enable_r;
        step_cnt_nxt = step_cnt_r;
        burst_start_nxt = 1'b0;
        burst_len_nxt = burst_len_r;
        step_start_nxt = 1'b0;
        targets_nxt = delay_step_targets_r;
        if (wr.wr) begin
            case (wr.addr)
                sfp_pkg::ADDR_BURST_PULSE_COUNT: begin
                    burst_cnt_nxt = wr.data[sfp_pkg::BURST_COUNT_MSB:sfp_pkg::BURST_COUNT_LSB];
                    if (pulser_ready) begin
                        burst_start_nxt = 1'b1;
                        burst_len_nxt = 4'h1 << wr.data[sfp_pkg::BURST_COUNT_MSB:sfp_pkg::BURST_COUNT_LSB];
                    end
                end
                sfp_pkg::ADDR_LOOP_FEEDBACK_SELECT: begin
                    loop_nxt = wr.data & sfp_pkg::MASK_LOOP_FEEDBACK_SELECT;
                end
                sfp_pkg::ADDR_BLOCK_POWER_DOWN: begin
                    power_nxt = wr.data;
                end
                sfp_pkg::ADDR_DYNAMIC_DELAY_ENABLE: begin
                    dde_nxt = wr.data;
                end
                sfp_pkg::ADDR_DELAY_STEP_COUNT: begin
                    step_cnt_nxt = wr.data;
                    if (wr.data != 8'h00 && output_dyn_delay_enable_r != 8'h00 && !delay_busy) begin
                        step_start_nxt = 1'b1;
                        targets_nxt = output_dyn_delay_enable_r;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Per-output frame-reference powerdown under the global bit
    for (genvar i = 0; i < NUM_FR_OUT; i++) begin : g_fr_off
        assign fr_off_nxt[i] = power_ctrl_r.frame_ref_global_powerdown & per_output_disable_mode[i];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            burst_cnt_r <= sfp_pkg::RST_BURST_PULSE_COUNT[1:0];
            loop_ctrl_r <= sfp_pkg::RST_LOOP_FEEDBACK_SELECT;
            power_ctrl_r <= sfp_pkg::RST_BLOCK_POWER_DOWN;
            output_dyn_delay_enable_r <= sfp_pkg::RST_DYNAMIC_DELAY_ENABLE;
            step_cnt_r <= sfp_pkg::RST_DELAY_STEP_COUNT;
            burst_start_r <= 1'b0;
            burst_len_r <= 4'h0;
            step_start_r <= 1'b0;
            delay_step_targets_r <= 8'h00;
            frame_ref_output_off_r <= '0;
            frame_ref_sync_avail_r <= 1'b0;
        end else begin
            burst_cnt_r <= burst_cnt_nxt;
            loop_ctrl_r <= loop_nxt;
            power_ctrl_r <= power_nxt;
            output_dyn_delay_enable_r <= dde_nxt;
            step_cnt_r <= step_cnt_nxt;
            burst_start_r <= burst_start_nxt;
            burst_len_r <= burst_len_nxt;
            step_start_r <= step_start_nxt;
            delay_step_targets_r <= targets_nxt;
            frame_ref_output_off_r <= fr_off_nxt;
            frame_ref_sync_avail_r <= !power_ctrl_r.frame_ref_block_powerdown;
        end
    end

    sfp_pulse_seq #(.CNT_W(4), .GAP_CYC(GAP_CYC)) u_burst (
        .core_clk(core_clk),
        .srst(srst),
        .start(burst_start_r),
        .count(burst_len_r),
        .pulse_r(frame_ref_burst_pulse),
        .busy_r(burst_busy)
    );

    sfp_pulse_seq #(.CNT_W(8), .GAP_CYC(GAP_CYC)) u_step (
        .core_clk(core_clk),
        .srst(srst),
        .start(step_start_r),
        .count(step_cnt_r),
        .pulse_r(delay_step_pulse),
        .busy_r(delay_busy)
    );

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_burst_write;
        wr.wr && wr.addr == sfp_pkg::ADDR_BURST_PULSE_COUNT;
    endsequence

    sequence s_step_write;
        wr.wr && wr.addr == sfp_pkg::ADDR_DELAY_STEP_COUNT && wr.data != 8'h00;
    endsequence

    a_burst_launch: assert property ((s_burst_write and (pulser_ready && !burst_busy))
        |=> burst_start_r ##1 frame_ref_burst_pulse)
        else $error("burst write did not launch pulses");
    a_burst_blocked_pd: assert property ((s_burst_write and power_ctrl_r.pulse_generator_powerdown) |=> !burst_start_r)
        else $error("burst launched with pulse generator down");
    a_burst_needs_pulser: assert property ((s_burst_write and frame_ref_source_select != sfp_pkg::SRC_PULSER)
        |=> !burst_start_r)
        else $error("burst launched without pulser source");
    a_burst_length_code: assert property (burst_start_r |-> burst_len_r == (4'h1 << burst_cnt_r))
        else $error("burst length does not match count code");
    a_sync_avail_pd: assert property (power_ctrl_r.frame_ref_block_powerdown |=> !frame_ref_sync_avail_r)
        else $error("sync shown available while powered down");
    a_step_starts: assert property ((s_step_write and output_dyn_delay_enable_r != 8'h00 and !delay_busy)
        |=> step_start_r ##1 delay_step_pulse)
        else $error("step write did not start adjustment");
    a_step_zero_none: assert property ((wr.wr && wr.addr == sfp_pkg::ADDR_DELAY_STEP_COUNT && wr.data == 8'h00)
        |=> !step_start_r)
        else $error("zero step count started adjustment");
    a_loop_reserved_zero: assert property (!loop_ctrl_r.reserved6)
        else $error("reserved feedback bit set");
    a_global_pd_gate: assert property (!power_ctrl_r.frame_ref_global_powerdown |=> frame_ref_output_off_r == '0)
        else $error("output off without global powerdown");
    a_power_follows_write: assert property ((wr.wr && wr.addr == sfp_pkg::ADDR_BLOCK_POWER_DOWN)
        |=> power_ctrl_r == $past(wr.data))
        else $error("power register did not take write");
    a_burst_count_store: assert property (s_burst_write |=> burst_cnt_r == $past(wr.data[1:0]))
        else $error("burst count field did not take write");
    a_loop_follows_write: assert property ((wr.wr && wr.addr == sfp_pkg::ADDR_LOOP_FEEDBACK_SELECT)
        |=> loop_ctrl_r == ($past(wr.data) & sfp_pkg::MASK_LOOP_FEEDBACK_SELECT))
        else $error("feedback register did not take write");
    a_dde_follows_write: assert property ((wr.wr && wr.addr == sfp_pkg::ADDR_DYNAMIC_DELAY_ENABLE)
        |=> output_dyn_delay_enable_r == $past(wr.data))
        else $error("delay enable register did not take write");
    a_step_targets_capture: assert property (step_start_r
        |-> delay_step_targets_r == $past(output_dyn_delay_enable_r))
        else $error("step targets differ from enable mask");
    a_step_no_targets: assert property ((s_step_write and output_dyn_delay_enable_r == 8'h00)
        |=> !step_start_r)
        else $error("step started with no enabled outputs");
endmodule

// file: dv/sfp_regs_test.sv
`timescale 1ns/1ns
module sfp_regs_test;
    logic core_clk;
    logic srst;
    logic spi_sck;
    logic spi_cs_n;
    logic spi_sdi;
    logic spi_sdo;
    logic spi_sdo_oe_n;
    logic [1:0] frame_ref_source_select;
    logic [1:0] sync_mode;
    logic [6:0] per_output_disable_mode;
    sfp_pkg::sfp_loop_t loop_ctrl_r;
    sfp_pkg::sfp_power_t power_ctrl_r;
    logic [6:0] frame_ref_output_off_r;
    logic frame_ref_sync_avail_r;
    logic frame_ref_burst_pulse;
    logic burst_busy;
    logic [7:0] output_dyn_delay_enable_r;
    logic [7:0] delay_step_targets_r;
    logic delay_step_pulse;
    logic delay_busy;
    int failures = 0;
    int cmp_count = 0;
    int burst_cnt = 0;
    int step_cnt = 0;
    logic [7:0] rd;
    logic oe_mid;

    sfp_regs dut (
        .core_clk(core_clk),
        .srst(srst),
        .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n),
        .frame_ref_source_select(frame_ref_source_select),
        .sync_mode(sync_mode),
        .per_output_disable_mode(per_output_disable_mode),
        .loop_ctrl_r(loop_ctrl_r),
        .power_ctrl_r(power_ctrl_r),
        .frame_ref_output_off_r(frame_ref_output_off_r),
        .frame_ref_sync_avail_r(frame_ref_sync_avail_r),
        .frame_ref_burst_pulse(frame_ref_burst_pulse),
        .burst_busy(burst_busy),
        .output_dyn_delay_enable_r(output_dyn_delay_enable_r),
        .delay_step_targets_r(delay_step_targets_r),
        .delay_step_pulse(delay_step_pulse),
        .delay_busy(delay_busy)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Pulse counters sample the registered outputs before each edge lands
    always @(posedge core_clk) begin
        if (frame_ref_burst_pulse === 1'b1) burst_cnt++;
        if (delay_step_pulse === 1'b1) step_cnt++;
    end

    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // One 24-bit frame; sck low 4 clocks and high 5, sdo taken just before each of the last 8 rises
    task automatic spi_xfer(input logic rw, input logic [12:0] addr, input logic [7:0] wd,
                            output logic [7:0] rdv);
        logic [23:0] frame;
        frame = {rw, 2'b00, addr, wd};
        rdv = 8'h00;
        @(posedge core_clk);
        spi_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge core_clk);
            spi_sck <= 1'b0;
            spi_sdi <= frame[i];
            repeat (4) @(posedge core_clk);
            if (i < 8) rdv[i] = spi_sdo;
            if (i == 0) oe_mid = spi_sdo_oe_n;
            spi_sck <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
        @(posedge core_clk);
        spi_sck <= 1'b0;
        repeat (4) @(posedge core_clk);
        spi_cs_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic wr(input logic [12:0] addr, input logic [7:0] d);
        logic [7:0] dummy;
        spi_xfer(1'b0, addr, d, dummy);
        chk_reg("sdo_oe_n write", 8'h01, {7'h00, oe_mid});
    endtask

    task automatic rd_chk(input string what, input logic [12:0] addr, input logic [7:0] exp);
        spi_xfer(1'b1, addr, 8'h00, rd);
        chk_reg(what, exp, rd);
        chk_reg("sdo_oe_n read data", 8'h00, {7'h00, oe_mid});
        chk_reg("sdo_oe_n idle", 8'h01, {7'h00, spi_sdo_oe_n});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while ((burst_busy !== 1'b0 || delay_busy !== 1'b0) && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 2000) begin
            failures++;
            $display("MISMATCH busy expected 0 seen 1");
        end
        repeat (3) @(posedge core_clk);
    endtask

    task automatic t_reset();
        chk_reg("power_ctrl", 8'he0, power_ctrl_r);
        chk_reg("sync_avail", 8'h01, {7'h00, frame_ref_sync_avail_r});
        rd_chk("rd burst", 13'h013e, 8'h03);
        rd_chk("rd loop", 13'h013f, 8'h00);
        rd_chk("rd power", 13'h0140, 8'he0);
        rd_chk("rd dde", 13'h0141, 8'h00);
        rd_chk("rd step", 13'h0142, 8'h00);
        rd_chk("rd unmapped", 13'h0150, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_loop();
        logic [7:0] pat [9] = '{8'h80, 8'h40, 8'h20, 8'h18, 8'h10, 8'h06, 8'h02, 8'h01, 8'hff};
        foreach (pat[k]) begin
            wr(13'h013f, pat[k]);
            chk_reg("loop_ctrl", pat[k] & 8'hbf, loop_ctrl_r);
            rd_chk("rd loop", 13'h013f, pat[k] & 8'hbf);
        end
        wr(13'h013e, 8'hff);
        rd_chk("rd burst", 13'h013e, 8'h03);
        wr(13'h0150, 8'h00);
        rd_chk("rd burst after unmapped", 13'h013e, 8'h03);
        $display("test loop done");
    endtask

    task automatic t_power();
        logic [7:0] pat [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
        foreach (pat[k]) begin
            wr(13'h0140, pat[k]);
            chk_reg("power_ctrl", pat[k], power_ctrl_r);
            chk_reg("fr_off", pat[k][3] ? 8'h55 : 8'h00, {1'b0, frame_ref_output_off_r});
            chk_reg("sync_avail", {7'h00, ~pat[k][2]}, {7'h00, frame_ref_sync_avail_r});
            rd_chk("rd power", 13'h0140, pat[k]);
        end
        $display("test power done");
    endtask

    task automatic t_burst();
        // Each entry: source, sync mode, power byte; none may fire
        logic [11:0] gate [6] = '{{2'h0, 2'h3, 8'h00}, {2'h1, 2'h3, 8'h00}, {2'h3, 2'h3, 8'h00},
                                  {2'h2, 2'h2, 8'h00}, {2'h2, 2'h3, 8'h01}, {2'h2, 2'h3, 8'h04}};
        int b0;
        frame_ref_source_select <= 2'h2;
        sync_mode <= 2'h3;
        wr(13'h0140, 8'h00);
        for (int c = 0; c < 4; c++) begin
            b0 = burst_cnt;
            wr(13'h013e, c[7:0]);
            wait_idle();
            chk_cnt("burst pulses", 1 << c, burst_cnt - b0);
        end
        foreach (gate[k]) begin
            frame_ref_source_select <= gate[k][11:10];
            sync_mode <= gate[k][9:8];
            wr(13'h0140, gate[k][7:0]);
            b0 = burst_cnt;
            wr(13'h013e, 8'h03);
            wait_idle();
            chk_cnt("gated burst", 0, burst_cnt - b0);
        end
        $display("test burst done");
    endtask

    task automatic t_step();
        logic [7:0] n [4] = '{8'h01, 8'h05, 8'h00, 8'hff};
        int s0;
        sync_mode <= 2'h3;
        wr(13'h0141, 8'h81);
        chk_reg("dde", 8'h81, output_dyn_delay_enable_r);
        foreach (n[k]) begin
            s0 = step_cnt;
            wr(13'h0142, n[k]);
            wait_idle();
            chk_cnt("step pulses", int'(n[k]), step_cnt - s0);
        end
        chk_reg("targets", 8'h81, delay_step_targets_r);
        rd_chk("rd step", 13'h0142, 8'hff);
        wr(13'h0141, 8'h00);
        s0 = step_cnt;
        wr(13'h0142, 8'h03);
        wait_idle();
        chk_cnt("no targets", 0, step_cnt - s0);
        $display("test step done");
    endtask

    // Reset lands while a long adjustment runs
    task automatic t_mid_reset();
        wr(13'h0141, 8'h01);
        wr(13'h0140, 8'h1f);
        wr(13'h0142, 8'hff);
        repeat (20) @(posedge core_clk);
        srst <= 1'b1;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk_reg("delay_busy", 8'h00, {7'h00, delay_busy});
        chk_reg("power_ctrl", 8'he0, power_ctrl_r);
        chk_reg("dde", 8'h00, output_dyn_delay_enable_r);
        rd_chk("rd step", 13'h0142, 8'h00);
        rd_chk("rd burst", 13'h013e, 8'h03);
        $display("test mid reset done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
        frame_ref_source_select = 2'h0;
        sync_mode = 2'h0;
        per_output_disable_mode = 7'h55;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_loop();
        t_power();
        t_burst();
        t_step();
        t_mid_reset();
        wrap_up();
    end

    // About 80 frames of some 230 clocks plus pulse trains need under 20000 cycles
    initial begin
        #(20 * 40000);
        failures++;
        $display("MISMATCH watchdog expected done seen timeout");
        wrap_up();
    end
endmodule
